// >>> core/placeholder_unused.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> core/tox_pkg.sv
package tox_pkg;

  // widths and counts
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 16;
  localparam int POS_W     = 12;
  localparam int NUM_PINS  = 8;
  localparam int NUM_USER  = 4;
  localparam int USER_REGS = 5;   // hStart, hStop, vStart, vStop, control
  localparam int SEQ_W     = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] SEQ_RESET_ADDR  = 12'h01a;
  localparam logic [ADDR_W-1:0] AUDIO_CTRL_ADDR = 12'h020;
  localparam logic [ADDR_W-1:0] STD_SEL_ADDR    = 12'h021;
  localparam logic [ADDR_W-1:0] SEQ_STATUS_ADDR = 12'h022;
  localparam logic [ADDR_W-1:0] PIN_SEL_ADDR    = 12'h043;
  localparam logic [ADDR_W-1:0] POLARITY_ADDR   = 12'h04b;
  localparam logic [ADDR_W-1:0] USER_CFG_ADDR   = 12'h057;

  // field positions
  localparam int SEQ_RST_AFS_BIT    = 0;
  localparam int SEQ_RST_TFID_BIT   = 1;
  localparam int AUD_PIN_IGNORE_BIT = 0;
  localparam int AUD_FIELD_MODE_BIT = 1;
  localparam int STD_HOST_BIT       = 15;
  localparam int STD_ASR_LSB        = 6;
  localparam int SEL_DRIVE_BIT      = 4;
  localparam int USR_POL_BIT        = 0;
  localparam int USR_AND_BIT        = 1;
  localparam int USR_OR_BIT         = 2;
  localparam int USR_XOR_BIT        = 3;

  // reset values
  localparam logic [1:0]          AUDIO_CTRL_RESET = 2'h0;
  localparam logic [DATA_W-1:0]   STD_SEL_RESET    = 16'h0000;
  localparam logic [NUM_PINS-1:0] POLARITY_RESET   = 8'h00;
  localparam logic [DATA_W-1:0]   USER_REG_RESET   = 16'h0000;
  localparam logic [NUM_PINS-1:0][4:0] PIN_SEL_RESET = {
    5'h0a, 5'h08, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01};

  // interlaced 525-line standard
  localparam logic [5:0]       STD_525I      = 6'h03;
  localparam logic [POS_W-1:0] LINES_525_ODD = 12'h107;  // 263

  // crosspoint source codes
  typedef enum logic [3:0] {
    SRC_HIZ = 4'h0, SRC_HSYNC = 4'h1, SRC_HBLANK = 4'h2, SRC_VSYNC = 4'h3,
    SRC_VBLANK = 4'h4, SRC_FSYNC = 4'h5, SRC_FDIGITAL = 4'h6, SRC_TFID = 4'h7,
    SRC_DE = 4'h8, SRC_RSVD9 = 4'h9, SRC_AFS = 4'ha, SRC_USER1 = 4'hb,
    SRC_USER2 = 4'hc, SRC_USER3 = 4'hd, SRC_USER4 = 4'he, SRC_RSVD15 = 4'hf
  } tox_src_t;

  typedef enum logic [2:0] {FR24, FR25, FR2997, FR30, FR50, FR5994, FR60} tox_rate_t;

  // basic timing signals, already in their pin default polarity
  typedef struct packed {
    logic hSync;
    logic hBlank;
    logic vSync;
    logic vBlank;
    logic fSync;
    logic fDigital;
    logic tenFieldId;
    logic displayEnable;
  } tox_basic_t;

  // raster position from the timing core
  typedef struct packed {
    logic [POS_W-1:0] hPos;          // 1 at leading edge of h blanking
    logic [POS_W-1:0] vLine;         // frame line, 1 at leading edge of v blanking
    logic [POS_W-1:0] oddFieldLines; // lines in the first field
    logic             interlaced;
    logic             hSyncLead;     // one-cycle pulse at h sync leading edge
  } tox_count_t;

  typedef struct packed {
    logic [DATA_W-1:0] hStart;
    logic [DATA_W-1:0] hStop;
    logic [DATA_W-1:0] vStart;
    logic [DATA_W-1:0] vStop;
    logic [DATA_W-1:0] ctrl;
  } tox_user_cfg_t;

  // frame rate class of a video standard code
  function automatic tox_rate_t rateOfStd(input logic [5:0] std);
    unique case (std[2:0])
      3'h0: rateOfStd = FR60;
      3'h1: rateOfStd = FR5994;
      3'h2: rateOfStd = FR50;
      3'h3: rateOfStd = FR2997;
      3'h4: rateOfStd = FR25;
      3'h5: rateOfStd = FR30;
      3'h6: rateOfStd = FR24;
      default: rateOfStd = FR2997;
    endcase
  endfunction

  // frames per audio/video sequence; 96 kHz behaves as 48 kHz
  function automatic logic [SEQ_W-1:0] seqLength(input tox_rate_t rate,
                                                 input logic [2:0] asr);
    seqLength = 8'h01;
    unique case (asr)
      3'h1: begin
        if (rate == FR24) seqLength = 8'h02;
        if (rate == FR2997) seqLength = 8'h64;
        if (rate == FR5994) seqLength = 8'hc8;
      end
      3'h2: begin
        if (rate == FR24 || rate == FR30 || rate == FR60) seqLength = 8'h03;
        if (rate == FR2997 || rate == FR5994) seqLength = 8'h0f;
      end
      default: begin
        if (rate == FR2997 || rate == FR5994) seqLength = 8'h05;
      end
    endcase
  endfunction

endpackage

// >>> core/tox_timing_out.sv
// Summary of operation
// (RQ1) sync pulse at line 1, every nth frame
// (RQ2) n from standard and audio rate selection
// (RQ3) one line, or field-one to field-two span
// (RQ4) ten-field-id pin rephases, unless control bit0
// (RQ5) host write rephases the sequence counter
// (RQ6) host reset applied at next frame start
// (RQ7) four user pulses with h/v windows
// (RQ8) optional and/or/xor combining, off after reset
// (RQ9) plain user pulse follows h window
// (RQ10) and mode needs both h and v
// (RQ11) h span start+1 to stop, except 1
// (RQ12) even fields use start-1 and stop-1
// (RQ13) 525 interlaced: odd field 263 lines
// (RQ14) user registers start at 57h
// (RQ15) eight pins, defaults, remappable from 43h
// (RQ16) four-bit source code decode per pin
// (RQ17) no-audio variant ignores audio sync code
// (RQ18) drive strength per pin, low default
// (RQ19) polarity register inverts each pin
// (RQ20) all outputs registered on pixel clock
`timescale 1ns/10ps
`default_nettype none
module tox_timing_out #(
  parameter bit HAS_AUDIO = 1'b1
) (
  // clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  reset,
  // timing core
  input  wire tox_pkg::tox_basic_t                   basic,
  input  wire tox_pkg::tox_count_t                   cnt,
  // selection pins
  input  wire logic [5:0]                            videoStandardSel,
  input  wire logic [2:0]                            audioRateSel,
  input  wire logic                                  tenFieldIdIn,
  // host register port
  input  wire logic                                  regWrEn,
  input  wire logic                                  regRdEn,
  input  wire logic [tox_pkg::ADDR_W-1:0]            regAddr,
  input  wire logic [tox_pkg::DATA_W-1:0]            regWrData,
  output var  logic [tox_pkg::DATA_W-1:0]            regRdData_q,
  // timing output pins
  output var  logic [tox_pkg::NUM_PINS-1:0]          timingOut_q,
  output var  logic [tox_pkg::NUM_PINS-1:0]          timingOutEn_q,
  output var  logic [tox_pkg::NUM_PINS-1:0]          driveHigh_q,
  // request to the ten-field-id divider
  output var  logic                                  tenFieldIdReset_q
);

  localparam int NP = tox_pkg::NUM_PINS;
  localparam int NU = tox_pkg::NUM_USER;
  localparam int NR = tox_pkg::NUM_USER * tox_pkg::USER_REGS;

  // register state
  logic [1:0]                  seqPend_q;
  logic [1:0]                  audioCtrl_q;
  logic [tox_pkg::DATA_W-1:0]  stdSel_q;
  logic [NP-1:0][4:0]          pinSel_q;
  logic [NP-1:0]               polarity_q;
  logic [tox_pkg::DATA_W-1:0]  userReg_q [NR];

  // sequence state
  logic [tox_pkg::SEQ_W-1:0]   seqIdx_q;
  logic [tox_pkg::SEQ_W-1:0]   seqNext;
  logic [tox_pkg::SEQ_W-1:0]   seqLen;
  logic                        afs_q;
  tox_pkg::tox_basic_t         basic_q;
  logic [NU-1:0]               userOut;

  // decode helpers
  logic [5:0]                  stdEff;
  logic [2:0]                  asrEff;
  logic [11:0]                 oddLines;
  logic                        frameStart;
  logic                        field2Start;
  logic                        rephase;
  logic                        pinSelHit;
  logic                        userHit;
  logic [2:0]                  pinIdx;
  logic [4:0]                  userIdx;
  logic                        seqWrite;
  logic [15:0]                 srcVec;
  logic [tox_pkg::DATA_W-1:0]  rdData;

  assign pinSelHit = regAddr >= tox_pkg::PIN_SEL_ADDR
                  && regAddr < 12'(tox_pkg::PIN_SEL_ADDR + NP);
  assign userHit   = regAddr >= tox_pkg::USER_CFG_ADDR
                  && regAddr < 12'(tox_pkg::USER_CFG_ADDR + NR);
  assign pinIdx    = 3'(regAddr - tox_pkg::PIN_SEL_ADDR);
  assign userIdx   = 5'(regAddr - tox_pkg::USER_CFG_ADDR);
  assign seqWrite  = regWrEn && regAddr == tox_pkg::SEQ_RESET_ADDR;

  // pins or host registers choose the standard and audio rate
  assign stdEff = stdSel_q[tox_pkg::STD_HOST_BIT] ? stdSel_q[5:0] : videoStandardSel; // RQ2
  assign asrEff = stdSel_q[tox_pkg::STD_HOST_BIT]
                ? stdSel_q[tox_pkg::STD_ASR_LSB +: 3] : audioRateSel; // RQ2
  assign seqLen = tox_pkg::seqLength(tox_pkg::rateOfStd(stdEff), asrEff); // RQ2

  // the 525 interlaced first field is pinned at 263 lines
  assign oddLines = (stdEff == tox_pkg::STD_525I && cnt.interlaced)
                  ? tox_pkg::LINES_525_ODD : cnt.oddFieldLines; // RQ13

  // line 1 and first line of the second field, at the h sync leading edge
  assign frameStart  = cnt.hSyncLead && cnt.vLine == 12'h001;
  assign field2Start = cnt.hSyncLead && cnt.interlaced
                    && cnt.vLine == 12'(oddLines + 12'h001);

  // the pin rephases only while the control bit lets it; host request waits for frame
  assign rephase = (tenFieldIdIn && !audioCtrl_q[tox_pkg::AUD_PIN_IGNORE_BIT]) // RQ4
                || seqPend_q[tox_pkg::SEQ_RST_AFS_BIT]; // RQ5 RQ6
  assign seqNext = (rephase || 8'(seqIdx_q + 8'h01) >= seqLen) ? 8'h00
                 : 8'(seqIdx_q + 8'h01);

  // host sequence reset requests: set wins over the frame-start clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      seqPend_q <= 2'h0;
    end else begin
      seqPend_q <= (frameStart ? 2'h0 : seqPend_q)
                 | (seqWrite ? regWrData[1:0] : 2'h0); // RQ5 RQ6
    end
  end

  // ten-field-id divider reset leaves as one pulse at frame start
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tenFieldIdReset_q <= 1'b0;
    end else begin
      tenFieldIdReset_q <= frameStart && seqPend_q[tox_pkg::SEQ_RST_TFID_BIT]; // RQ6
    end
  end

  // divide-by-n frame counter
  always_ff @(posedge core_clk) begin
    if (reset) begin
      seqIdx_q <= 8'h00;
    end else if (frameStart) begin
      seqIdx_q <= seqNext; // RQ1 RQ4 RQ5
    end
  end

  // audio frame sync: rises at line 1 of a sequence frame
  always_ff @(posedge core_clk) begin
    if (reset) begin
      afs_q <= 1'b0;
    end else if (frameStart && seqNext == 8'h00) begin
      afs_q <= 1'b1; // RQ1
    end else if (!audioCtrl_q[tox_pkg::AUD_FIELD_MODE_BIT]) begin
      if (cnt.hSyncLead) begin
        afs_q <= 1'b0; // RQ3
      end
    end else if (field2Start || frameStart) begin
      afs_q <= 1'b0; // RQ3
    end
  end

  // control registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      audioCtrl_q <= tox_pkg::AUDIO_CTRL_RESET;
      stdSel_q    <= tox_pkg::STD_SEL_RESET;
      polarity_q  <= tox_pkg::POLARITY_RESET;
    end else if (regWrEn) begin
      if (regAddr == tox_pkg::AUDIO_CTRL_ADDR) begin
        audioCtrl_q <= regWrData[1:0]; // RQ3 RQ4
      end
      if (regAddr == tox_pkg::STD_SEL_ADDR) begin
        stdSel_q <= regWrData; // RQ2
      end
      if (regAddr == tox_pkg::POLARITY_ADDR) begin
        polarity_q <= regWrData[NP-1:0]; // RQ19
      end
    end
  end

  // pin source selectors; the no-audio part keeps its old source on code 1010
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pinSel_q <= tox_pkg::PIN_SEL_RESET; // RQ15 RQ18
    end else if (regWrEn && pinSelHit) begin
      pinSel_q[pinIdx][tox_pkg::SEL_DRIVE_BIT] <= regWrData[tox_pkg::SEL_DRIVE_BIT]; // RQ18
      if (HAS_AUDIO || regWrData[3:0] != tox_pkg::SRC_AFS) begin
        pinSel_q[pinIdx][3:0] <= regWrData[3:0]; // RQ15 RQ17
      end
    end
  end

  // user pulse programming words, combining off after reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NR; i++) begin
        userReg_q[i] <= tox_pkg::USER_REG_RESET; // RQ8
      end
    end else if (regWrEn && userHit) begin
      userReg_q[userIdx] <= regWrData; // RQ14
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdData = 16'h0000;
    if (regAddr == tox_pkg::SEQ_RESET_ADDR) begin
      rdData = {14'h0000, seqPend_q};
    end else if (regAddr == tox_pkg::AUDIO_CTRL_ADDR) begin
      rdData = {14'h0000, audioCtrl_q};
    end else if (regAddr == tox_pkg::STD_SEL_ADDR) begin
      rdData = stdSel_q;
    end else if (regAddr == tox_pkg::SEQ_STATUS_ADDR) begin
      rdData = {afs_q, 7'h00, seqIdx_q};
    end else if (regAddr == tox_pkg::POLARITY_ADDR) begin
      rdData = {8'h00, polarity_q};
    end else if (pinSelHit) begin
      rdData = {11'h000, pinSel_q[pinIdx]};
    end else if (userHit) begin
      rdData = userReg_q[userIdx];
    end
  end

  // read data held until the next read
  always_ff @(posedge core_clk) begin
    if (reset) begin
      regRdData_q <= 16'h0000;
    end else if (regRdEn) begin
      regRdData_q <= rdData;
    end
  end

  // one stage on the basic signals lines them up with the generated ones
  always_ff @(posedge core_clk) begin
    if (reset) begin
      basic_q <= '0;
    end else begin
      basic_q <= basic; // RQ20
    end
  end

  // user pulse generators
  for (genvar u = 0; u < NU; u++) begin : gUser
    tox_pkg::tox_user_cfg_t cfg;
    assign cfg = '{hStart: userReg_q[u*5], hStop: userReg_q[u*5+1],
                   vStart: userReg_q[u*5+2], vStop: userReg_q[u*5+3],
                   ctrl: userReg_q[u*5+4]};
    tox_user_pulse uPulse (
      .core_clk  (core_clk),
      .reset     (reset),
      .cfg       (cfg),
      .cnt       (cnt),
      .oddLines  (oddLines),
      .userOut_q (userOut[u])
    );
  end

  // crosspoint source vector, indexed by source code
  assign srcVec = {1'b0, userOut[3], userOut[2], userOut[1], userOut[0],
                   afs_q, 1'b0, basic_q.displayEnable, basic_q.tenFieldId,
                   basic_q.fDigital, basic_q.fSync, basic_q.vBlank, basic_q.vSync,
                   basic_q.hBlank, basic_q.hSync, 1'b0}; // RQ16

  // crosspoint: any source to any pin, several pins may share one
  for (genvar p = 0; p < NP; p++) begin : gPin
    logic [3:0] code;
    logic       valid;
    assign code  = pinSel_q[p][3:0];
    // high impedance and reserved codes leave the pin undriven
    assign valid = code != tox_pkg::SRC_HIZ && code != tox_pkg::SRC_RSVD9
                && code != tox_pkg::SRC_RSVD15; // RQ16
    always_ff @(posedge core_clk) begin
      if (reset) begin
        timingOut_q[p]   <= 1'b0;
        timingOutEn_q[p] <= 1'b0;
        driveHigh_q[p]   <= 1'b0;
      end else begin
        timingOut_q[p]   <= srcVec[code] ^ polarity_q[p]; // RQ15 RQ19 RQ20
        timingOutEn_q[p] <= valid; // RQ16
        driveHigh_q[p]   <= pinSel_q[p][tox_pkg::SEL_DRIVE_BIT]; // RQ18
      end
    end
  end

endmodule // tox_timing_out
`default_nettype wire

// >>> core/tox_user_pulse.sv
`timescale 1ns/10ps
`default_nettype none
module tox_user_pulse (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // configuration and raster
  input  wire tox_pkg::tox_user_cfg_t cfg,
  input  wire tox_pkg::tox_count_t   cnt,
  input  wire logic [11:0]           oddLines,
  // pulse in pin polarity, active low by default
  output var  logic                  userOut_q
);

  logic [11:0] hFirst;
  logic [11:0] vFirst;
  logic [11:0] vLast;
  logic [11:0] evenLine;
  logic        evenField;
  logic        hActive;
  logic        vActive;
  logic        active;

  // a start of 1 keeps pixel 1, so no pulse can open on pixel 2
  assign hFirst = (cfg.hStart[11:0] == 12'h001) ? 12'h001 : 12'(cfg.hStart[11:0] + 12'h001); // RQ11
  assign hActive = (cnt.hPos >= hFirst) && (cnt.hPos <= cfg.hStop[11:0]); // RQ11 RQ7

  // second field lines mapped back to field-relative numbers, one line earlier
  assign evenField = cnt.interlaced && (cnt.vLine > oddLines); // RQ13
  assign evenLine  = 12'(cnt.vLine - oddLines);
  assign vFirst    = evenField ? 12'(cfg.vStart[11:0] - 12'h001) : cfg.vStart[11:0]; // RQ12
  assign vLast     = evenField ? 12'(cfg.vStop[11:0] - 12'h001) : cfg.vStop[11:0]; // RQ12
  assign vActive   = evenField ? (evenLine >= vFirst && evenLine <= vLast)
                               : (cnt.vLine >= vFirst && cnt.vLine <= vLast);

  // combining: and wins over or, or over xor; none leaves the h pulse alone
  always_comb begin
    if (cfg.ctrl[tox_pkg::USR_AND_BIT]) begin
      active = hActive && vActive; // RQ10
    end else if (cfg.ctrl[tox_pkg::USR_OR_BIT]) begin
      active = hActive || vActive; // RQ8
    end else if (cfg.ctrl[tox_pkg::USR_XOR_BIT]) begin
      active = hActive ^ vActive; // RQ8
    end else begin
      active = hActive; // RQ9
    end
  end

  // registered so it leaves on the same edge as the basic signals
  always_ff @(posedge core_clk) begin
    if (reset) begin
      userOut_q <= 1'b1;
    end else begin
      userOut_q <= ~active ^ cfg.ctrl[tox_pkg::USR_POL_BIT]; // RQ20 RQ7
    end
  end

endmodule // tox_user_pulse
`default_nettype wire

// >>> tb/tox_app_sink.sv
`timescale 1ns/10ps
`default_nettype none
module tox_app_sink (
  // clock
  input  wire logic       core_clk,
  // timing pins from the device
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinEn,
  // level seen by the application
  output logic      [7:0] pinLvl
);
  logic [7:0] lastLvl_q;
  // no pull on these lines: a released pin drifts, so it shows the inverse of its last level
  assign pinLvl = (pinEn & pinOut) | (~pinEn & ~lastLvl_q);
  // remember the last level so an undriven pin toggles every cycle
  always_ff @(posedge core_clk) begin
    lastLvl_q <= pinLvl;
  end
endmodule  // tox_app_sink
`default_nettype wire

// >>> tb/tox_timing_out_chk.sv
`timescale 1ns/10ps
`default_nettype none
module tox_timing_out_chk #(
  parameter bit HAS_AUDIO = 1'b1
) (
  // clock and reset
  input wire logic                          core_clk,
  input wire logic                          reset,
  // inputs
  input wire tox_pkg::tox_basic_t           basic,
  input wire tox_pkg::tox_count_t           cnt,
  input wire logic                          regWrEn,
  input wire logic                          regRdEn,
  input wire logic [tox_pkg::ADDR_W-1:0]    regAddr,
  input wire logic [tox_pkg::DATA_W-1:0]    regWrData,
  // outputs
  input wire logic [tox_pkg::DATA_W-1:0]    regRdData_q,
  input wire logic [tox_pkg::NUM_PINS-1:0]  timingOut_q,
  input wire logic [tox_pkg::NUM_PINS-1:0]  timingOutEn_q,
  input wire logic [tox_pkg::NUM_PINS-1:0]  driveHigh_q,
  input wire logic                          tenFieldIdReset_q
);
  logic [7:0][4:0] sel_q;
  logic [7:0]      pol_q;
  logic [3:0]      age_q;
  logic [7:0]      b1_q;
  logic [7:0]      b2_q;
  // shadow of routing registers; age lets checks skip the settling cycles after a write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sel_q <= tox_pkg::PIN_SEL_RESET;
      pol_q <= tox_pkg::POLARITY_RESET;
      age_q <= 4'h0;
    end else begin
      age_q <= regWrEn ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
      if (regWrEn && regAddr == tox_pkg::POLARITY_ADDR) pol_q <= regWrData[7:0];
      for (int p = 0; p < 8; p++) begin
        if (regWrEn && regAddr == tox_pkg::PIN_SEL_ADDR + 12'(p)) begin
          sel_q[p][4] <= regWrData[4];
          if (HAS_AUDIO || regWrData[3:0] != 4'ha) sel_q[p][3:0] <= regWrData[3:0];
        end
      end
    end
  end
  // basic inputs delayed to pin alignment
  always_ff @(posedge core_clk) begin
    b1_q <= basic;
    b2_q <= b1_q;
  end
  for (genvar p = 0; p < 8; p++) begin : g_pin
    a_pin_route: assert property (
      @(posedge core_clk) disable iff (reset)
      age_q > 4'h4 && sel_q[p][3:0] inside {[4'h1:4'h8]} |->
      timingOutEn_q[p] && timingOut_q[p] == (b2_q[4'h8 - sel_q[p][3:0]] ^ pol_q[p]))
      else $error("pin level differs from its routed source");
    a_pin_undriven: assert property (
      @(posedge core_clk) disable iff (reset)
      age_q > 4'h4 && sel_q[p][3:0] inside {4'h0, 4'h9, 4'hf} |->
      !timingOutEn_q[p] && timingOut_q[p] == pol_q[p])
      else $error("undriven code still drives pin");
    a_drive_bit: assert property (
      @(posedge core_clk) disable iff (reset)
      age_q > 4'h4 |-> driveHigh_q[p] == sel_q[p][4])
      else $error("drive strength differs from selector");
  end
  a_reset_clear: assert property (
    @(posedge core_clk) reset |=> timingOut_q == 8'h00 && timingOutEn_q == 8'h00
      && driveHigh_q == 8'h00 && regRdData_q == 16'h0000 && !tenFieldIdReset_q)
    else $error("outputs not cleared by reset");
  a_read_hold: assert property (
    @(posedge core_clk) disable iff (reset) !regRdEn |=> $stable(regRdData_q))
    else $error("read data moved without a read");
  a_read_unmapped: assert property (
    @(posedge core_clk) disable iff (reset)
    regRdEn && regAddr == 12'h0ff |=> regRdData_q == 16'h0000)
    else $error("unmapped read not zero");
  a_tfid_single: assert property (
    @(posedge core_clk) disable iff (reset) tenFieldIdReset_q |=> !tenFieldIdReset_q)
    else $error("divider reset wider than one cycle");
  a_tfid_frame: assert property (
    @(posedge core_clk) disable iff (reset)
    tenFieldIdReset_q |-> $past(cnt.hSyncLead && cnt.vLine == 12'h001))
    else $error("divider reset away from frame start");
endmodule  // tox_timing_out_chk
bind tox_timing_out tox_timing_out_chk #(.HAS_AUDIO(HAS_AUDIO)) tox_timing_out_chk_inst (
  .core_clk(core_clk), .reset(reset), .basic(basic), .cnt(cnt), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData_q(regRdData_q),
  .timingOut_q(timingOut_q), .timingOutEn_q(timingOutEn_q), .driveHigh_q(driveHigh_q),
  .tenFieldIdReset_q(tenFieldIdReset_q));
`default_nettype wire

// >>> tb/tox_timing_out_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tox_timing_out_tb;
  logic                core_clk;
  logic                reset;
  logic                regWrEn;
  logic                regRdEn;
  logic                tfIn;
  logic                tfReq;
  tox_pkg::tox_basic_t basic;
  tox_pkg::tox_count_t cnt;
  logic [5:0]          vidStd;
  logic [2:0]          audRate;
  logic [11:0]         regAddr;
  logic [15:0]         regWrData;
  logic [15:0]         rdData;
  logic [7:0]          tOut;
  logic [7:0]          tEn;
  logic [7:0]          drv;
  logic [7:0]          pinLvl;
  int                  fails = 0;
  int                  n_checks = 0;
  int                  tfCount = 0;

  tox_timing_out tox_timing_out_inst (
    .core_clk(core_clk), .reset(reset), .basic(basic), .cnt(cnt),
    .videoStandardSel(vidStd), .audioRateSel(audRate), .tenFieldIdIn(tfIn),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData_q(rdData), .timingOut_q(tOut), .timingOutEn_q(tEn), .driveHigh_q(drv),
    .tenFieldIdReset_q(tfReq));
  tox_app_sink tox_app_sink_inst (.core_clk(core_clk), .pinOut(tOut), .pinEn(tEn),
    .pinLvl(pinLvl));

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [11:0] a, logic [15:0] d);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask
  // read data lands on the same edge that takes the request
  task automatic rd(logic [11:0] a, logic [15:0] exp, string what);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    idle(1);
    chk(what, exp, rdData);
  endtask
  // one h sync lead on a line, line 1 (frame start) by default, then idle
  task automatic frame(logic t, logic [11:0] ln = 12'h001);
    @(posedge core_clk);
    cnt.hSyncLead <= 1'b1;
    cnt.vLine <= ln;
    tfIn <= t;
    @(posedge core_clk);
    cnt.hSyncLead <= 1'b0;
    cnt.vLine <= 12'h002;
    tfIn <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // the run needs about four hundred cycles; twenty thousand means a hang
  initial begin
    #200000;
    fails++;
    summarize();
  end
  always @(posedge core_clk) if (tfReq === 1'b1) tfCount++;

  initial begin
    reset = 1'b1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 12'h000;
    regWrData = 16'h0000;
    basic = 8'ha5;
    cnt = '0;
    cnt.vLine = 12'h002;
    vidStd = 6'h03;
    audRate = 3'h0;
    tfIn = 1'b0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    for (int p = 0; p < 8; p++) begin
      rd(tox_pkg::PIN_SEL_ADDR + 12'(p), 16'(tox_pkg::PIN_SEL_RESET[p]), "selector");
    end
    rd(tox_pkg::POLARITY_ADDR, 16'h0000, "polarity");
    rd(tox_pkg::USER_CFG_ADDR + 12'h004, 16'h0000, "user ctrl");
    rd(12'h0ff, 16'h0000, "unmapped");
    for (int p = 0; p < 7; p++) begin
      chk("default pin", 16'(basic[4'h8 - tox_pkg::PIN_SEL_RESET[p][3:0]]), 16'(pinLvl[p]));
    end
    $display("test reset values done");
    // every plain and undriven source code, drive bit alternating
    for (int c = 0; c < 16; c++) begin
      if (c < 10 || c == 15) begin
        wr(tox_pkg::PIN_SEL_ADDR, 16'(c) | {11'h0, c[0], 4'h0});
        idle(4);
        chk("enable", 16'(c inside {[1:8]}), 16'(tEn[0]));
        chk("drive", 16'(c[0]), 16'(drv[0]));
        if (c inside {[1:8]}) chk("level", 16'(basic[8-c]), 16'(pinLvl[0]));
      end
    end
    wr(tox_pkg::PIN_SEL_ADDR, 16'h0008);
    wr(tox_pkg::POLARITY_ADDR, 16'h0001);
    idle(4);
    chk("inverted", 16'(!basic[0]), 16'(pinLvl[0]));
    $display("test crosspoint done");
    wr(tox_pkg::POLARITY_ADDR, 16'h0000);
    wr(tox_pkg::PIN_SEL_ADDR, 16'h000b);
    // horizontal window, ordinary start and the start of 1
    for (int s = 1; s < 6; s += 4) begin
      wr(tox_pkg::USER_CFG_ADDR, 16'(s));
      wr(tox_pkg::USER_CFG_ADDR + 12'h001, 16'h0008);
      for (int h = 1; h < 13; h++) begin
        @(posedge core_clk);
        cnt.hPos <= 12'(h);
        idle(3);
        chk("user h", 16'(!(h <= 8 && (h > s || s == 1))), 16'(pinLvl[0]));
      end
    end
    wr(tox_pkg::USER_CFG_ADDR + 12'h002, 16'h0003);
    wr(tox_pkg::USER_CFG_ADDR + 12'h003, 16'h0005);
    wr(tox_pkg::USER_CFG_ADDR + 12'h004, 16'h0002);
    for (int v = 2; v < 5; v += 2) begin
      @(posedge core_clk);
      cnt.hPos <= 12'h006;
      cnt.vLine <= 12'(v);
      idle(3);
      chk("user and", 16'(v == 2), 16'(pinLvl[0]));
    end
    wr(tox_pkg::USER_CFG_ADDR + 12'h004, 16'h0008);
    idle(3);
    chk("user xor", 16'h0001, 16'(pinLvl[0]));
    @(posedge core_clk);
    cnt.vLine <= 12'h002;
    $display("test user pulse done");
    // five frame sequence from the standard pins, host rephase first
    wr(tox_pkg::SEQ_RESET_ADDR, 16'h0003);
    rd(tox_pkg::SEQ_RESET_ADDR, 16'h0003, "pending");
    frame(1'b0);
    rd(tox_pkg::SEQ_RESET_ADDR, 16'h0000, "pending cleared");
    chk("divider pulses", 16'h0001, 16'(tfCount));
    for (int f = 1; f < 7; f++) begin
      rd(tox_pkg::SEQ_STATUS_ADDR, {f % 5 == 1, 7'h0, 8'((f - 1) % 5)}, "index");
      chk("sync pin", 16'(f % 5 == 1), 16'(pinLvl[7]));
      frame(1'b0);
    end
    frame(1'b1);
    rd(tox_pkg::SEQ_STATUS_ADDR, 16'h8000, "pin rephase");
    wr(tox_pkg::AUDIO_CTRL_ADDR, 16'h0001);
    frame(1'b1);
    rd(tox_pkg::SEQ_STATUS_ADDR, 16'h0001, "pin ignored");
    wr(tox_pkg::AUDIO_CTRL_ADDR, 16'h0003);
    wr(tox_pkg::SEQ_RESET_ADDR, 16'h0001);
    cnt.interlaced <= 1'b1;
    frame(1'b0);
    frame(1'b0, 12'h002);
    idle(1);
    chk("field sync held", 16'h0001, 16'(pinLvl[7]));
    frame(1'b0, 12'h108);
    idle(1);
    chk("field sync end", 16'h0000, 16'(pinLvl[7]));
    @(posedge core_clk);
    cnt.vLine <= 12'h109;
    idle(3);
    chk("even field", 16'h0001, 16'(pinLvl[0]));
    wr(tox_pkg::STD_SEL_ADDR, 16'h8002);
    frame(1'b0);
    rd(tox_pkg::SEQ_STATUS_ADDR, 16'h8000, "host standard");
    $display("test frame sync done");
    summarize();
  end
endmodule  // tox_timing_out_tb
`default_nettype wire
